// ===== core/hwmon_defs.vh
// register map, field positions, reset values and timing counts of the monitor sequencer
`ifndef HWMON_DEFS_VH
`define HWMON_DEFS_VH

// register indices; byte address is four times the index
`define IDX_CFG        8'h00
`define IDX_FAN_DIV    8'h05
`define IDX_ADC_CTRL   8'h0A
`define IDX_VAL_FIRST  8'h20
`define IDX_VAL_LAST   8'h29
`define IDX_IRQ_STAT   8'h40
`define IDX_IRQ_MASK   8'h41
`define IDX_INPUT_MODE 8'h42
`define IDX_FAN_MODE   8'h43

// configuration register fields
`define CFG_START      0
`define CFG_INT_CLEAR  3
`define CFG_REINIT     7

// reset values
`define CFG_RST        7'h00
`define FAN_DIV_RST    8'h50
`define ADC_CTRL_RST   8'h02
`define INPUT_MODE_RST 6'h00
`define ADC_RANGE_RST  3'h0

// fan divisor fields, code 0..3 selects 1, 2, 4, 8
`define FDIV_A_LSB     4
`define FDIV_B_LSB     6

// adc range field
`define ADC_RANGE_LSB  3

// status bits
`define ST_ROUND       0
`define ST_FAN_A       1
`define ST_FAN_B       2

// sequence items and value slots
`define ITEM_FAN_A     4'h8
`define ITEM_LAST      4'h9
`define SLOT_TEMP      4'h7
`define SEL_TEMP       3'h7

// timing
`define CLK_HZ         20000000
`define CLK_PERIOD_NS  50
`define RST_PULSE_NS   50
`define RST_PULSE_CYC  ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_HZ         22500
`define TICK_CYC       (`CLK_HZ / (2 * `OSC_HZ))
`define FAN_MAX        8'hFF

`endif

// ===== core/value_mem.v
// value memory: ten result words, one write port, registered read port
`timescale 1ns/1ns
module value_mem (
	// clock
	input  wire       core_clk,
	// write port
	input  wire       we,
	input  wire [3:0] waddr,
	input  wire [9:0] wdata,
	// read port
	input  wire [3:0] raddr,
	output reg  [9:0] rdata
);
	reg [9:0] mem [0:9];

	always @(posedge core_clk) begin
		if (we && waddr <= 4'h9) begin
			mem[waddr] <= wdata;
		end
		// out-of-range reads are never selected by the bus mux
		if (raddr <= 4'h9) begin
			rdata <= mem[raddr];
		end else begin
			rdata <= 10'h000;
		end
	end
endmodule

// ===== core/hw_monitor_sequencer.v
// monitoring sequencer with apb registers, fan counters and interrupt status
`timescale 1ns/1ns
`include "hwmon_defs.vh"
module hw_monitor_sequencer (
	// clock and reset
	input  wire        core_clk,
	input  wire        rstn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// pins
	input  wire        test_or_reset_input_n,
	input  wire        tach_input_a,
	input  wire        tach_input_b,
	// converter
	output reg         adc_start,
	output reg  [2:0]  adc_sel,
	output reg  [5:0]  adc_mode,
	output reg  [2:0]  adc_range,
	input  wire        adc_done,
	input  wire [9:0]  adc_data,
	// interrupt
	output reg         irq
);
	localparam S_IDLE  = 5'b00001;
	localparam S_CONV  = 5'b00010;
	localparam S_FWAIT = 5'b00100;
	localparam S_FCNT  = 5'b01000;
	localparam S_STORE = 5'b10000;

	// last prescaler count for a divisor code
	function [2:0] div_last;
		input [1:0] code;
		begin
			case (code)
				2'h0:    div_last = 3'h0;
				2'h1:    div_last = 3'h1;
				2'h2:    div_last = 3'h3;
				default: div_last = 3'h7;
			endcase
		end
	endfunction

	// value slot of a sequence item; temperature sits behind the channels
	function [3:0] slot_of;
		input [3:0] item;
		begin
			slot_of = (item == 4'h0) ? `SLOT_TEMP : (item < `ITEM_FAN_A) ? item - 4'h1 : item;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// reset sources
	reg  [1:0] rpin_sync_r;
	reg  [3:0] rpin_cnt_r;
	reg        pin_rst_r;
	reg        soft_rst_r;
	wire       srst = ~rstn | pin_rst_r | soft_rst_r;
	wire [3:0] rpin_cnt_nxt = (rpin_cnt_r == 4'hF) ? rpin_cnt_r : rpin_cnt_r + 4'h1;
	// apb decode
	wire [7:0] idx     = paddr[9:2];
	wire       aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	wire       is_val  = (idx >= `IDX_VAL_FIRST) && (idx <= `IDX_VAL_LAST);
	wire       is_reg  = (idx == `IDX_CFG) || (idx == `IDX_FAN_DIV) ||
	                     (idx == `IDX_ADC_CTRL) || (idx == `IDX_IRQ_STAT) ||
	                     (idx == `IDX_IRQ_MASK) || (idx == `IDX_INPUT_MODE) ||
	                     (idx == `IDX_FAN_MODE);
	wire       bad     = ~aligned || ~(is_reg || is_val) || (is_val && pwrite);
	wire       wr      = psel && penable && pready && pwrite && ~bad;
	// registers
	reg  [6:0] cfg_r;
	reg  [7:0] fan_div_r;
	reg  [7:0] adc_ctrl_r;
	reg  [2:0] irq_stat_r;
	reg  [2:0] irq_mask_r;
	reg  [1:0] fan_mode_r;
	wire       run = cfg_r[`CFG_START] & ~cfg_r[`CFG_INT_CLEAR];
	// sequencer and memory
	reg  [4:0] state_r;
	reg  [3:0] item_r;
	reg        mem_we_r;
	reg  [3:0] mem_waddr_r;
	reg  [9:0] mem_wdata_r;
	wire [9:0] mem_rdata;
	wire [3:0] item_nxt = (item_r == `ITEM_LAST) ? 4'h0 : item_r + 4'h1;
	// fan inputs and dividers
	reg  [1:0] tach_a_sync_r;
	reg  [1:0] tach_b_sync_r;
	reg        tach_prev_r;
	reg  [9:0] osc_cnt_r;
	reg  [2:0] pre_cnt_r;
	reg  [7:0] fan_cnt_r;
	wire       fan_b    = item_r[0];
	wire       tach_now = fan_b ? tach_b_sync_r[1] : tach_a_sync_r[1];
	wire       tach_rise = tach_now & ~tach_prev_r;
	wire [1:0] div_code = fan_b ? fan_div_r[`FDIV_B_LSB +: 2] : fan_div_r[`FDIV_A_LSB +: 2];
	wire       osc_tick = (osc_cnt_r == `TICK_CYC - 1);
	wire       fan_tick = osc_tick && (pre_cnt_r == div_last(div_code));
	wire [2:0] st_set;
	wire [2:0] st_clr = (wr && idx == `IDX_IRQ_STAT) ? pwdata[2:0] : 3'h0;

	value_mem u_mem (
		.core_clk (core_clk),
		.we       (mem_we_r),
		.waddr    (mem_waddr_r),
		.wdata    (mem_wdata_r),
		.raddr    (paddr[5:2]),
		.rdata    (mem_rdata)
	);
	////////////////////////////////////////////////////////////////////
	// pin synchronisers and reset catch; these only obey the reset input
	always @(posedge core_clk) begin
		if (!rstn) begin
			rpin_sync_r   <= 2'h3;
			rpin_cnt_r    <= 4'h0;
			pin_rst_r     <= 1'b0;
			soft_rst_r    <= 1'b0;
			tach_a_sync_r <= 2'h0;
			tach_b_sync_r <= 2'h0;
		end else begin
			rpin_sync_r   <= {rpin_sync_r[0], test_or_reset_input_n};
			tach_a_sync_r <= {tach_a_sync_r[0], tach_input_a};
			tach_b_sync_r <= {tach_b_sync_r[0], tach_input_b};
			if (!rpin_sync_r[1]) begin
				rpin_cnt_r <= rpin_cnt_nxt;
				pin_rst_r  <= (rpin_cnt_nxt >= `RST_PULSE_CYC);
			end else begin
				rpin_cnt_r <= 4'h0;
				pin_rst_r  <= 1'b0;
			end
			soft_rst_r <= wr && (idx == `IDX_CFG) && pwdata[`CFG_REINIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, pready and data from flops
	always @(posedge core_clk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= bad;
			prdata  <= 32'h0000_0000;
			if (!bad && !pwrite) begin
				if (is_val) begin
					// latest result readable at any time
					prdata <= {22'h0, mem_rdata};
				end else if (idx == `IDX_CFG) begin
					prdata <= {24'h0, 1'b0, cfg_r};
				end else if (idx == `IDX_FAN_DIV) begin
					prdata <= {24'h0, fan_div_r};
				end else if (idx == `IDX_ADC_CTRL) begin
					prdata <= {24'h0, adc_ctrl_r[7:6], adc_range, adc_ctrl_r[2:0]};
				end else if (idx == `IDX_IRQ_STAT) begin
					prdata <= {29'h0, irq_stat_r};
				end else if (idx == `IDX_IRQ_MASK) begin
					prdata <= {29'h0, irq_mask_r};
				end else if (idx == `IDX_INPUT_MODE) begin
					prdata <= {26'h0, adc_mode};
				end else begin
					prdata <= {30'h0, fan_mode_r};
				end
			end
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// register writes take effect on the completing edge
	always @(posedge core_clk) begin
		if (srst) begin
			cfg_r      <= `CFG_RST;
			fan_div_r  <= `FAN_DIV_RST;
			adc_ctrl_r <= `ADC_CTRL_RST;
			adc_range  <= `ADC_RANGE_RST;
			adc_mode   <= `INPUT_MODE_RST;
			irq_mask_r <= 3'h0;
			fan_mode_r <= 2'h0;
		end else if (wr) begin
			// start and interrupt-clear bits gate the run
			if (idx == `IDX_CFG) begin
				cfg_r <= pwdata[6:0];
			end
			if (idx == `IDX_FAN_DIV) begin
				fan_div_r <= pwdata[7:0];
			end
			if (idx == `IDX_ADC_CTRL) begin
				adc_ctrl_r <= pwdata[7:0];
				adc_range  <= pwdata[`ADC_RANGE_LSB +: 3];
			end
			// pairing and polarity to the converter
			if (idx == `IDX_INPUT_MODE) begin
				adc_mode <= pwdata[5:0];
			end
			if (idx == `IDX_IRQ_MASK) begin
				irq_mask_r <= pwdata[2:0];
			end
			if (idx == `IDX_FAN_MODE) begin
				fan_mode_r <= pwdata[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt status: set wins over write-one-to-clear
	// fan pins in interrupt mode are active-low levels
	assign st_set[`ST_ROUND] = (state_r == S_STORE) && (item_r == `ITEM_LAST);
	assign st_set[`ST_FAN_A] = fan_mode_r[0] && !tach_a_sync_r[1];
	assign st_set[`ST_FAN_B] = fan_mode_r[1] && !tach_b_sync_r[1];

	always @(posedge core_clk) begin
		if (srst) begin
			irq_stat_r <= 3'h0;
			irq       <= 1'b0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~st_clr) | st_set;
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////
	// oscillator tick at twice 22.5 kHz so divisor 1 fits the count formula
	always @(posedge core_clk) begin
		if (srst || state_r == S_STORE) begin
			osc_cnt_r <= 10'h000;
			pre_cnt_r <= 3'h0;
		end else if (osc_tick) begin
			osc_cnt_r <= 10'h000;
			pre_cnt_r <= fan_tick ? 3'h0 : pre_cnt_r + 3'h1;
		end else begin
			osc_cnt_r <= osc_cnt_r + 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sequencer
	always @(posedge core_clk) begin
		if (srst) begin
			state_r     <= S_IDLE;
			item_r      <= 4'h0;
			adc_start   <= 1'b0;
			adc_sel     <= `SEL_TEMP;
			mem_we_r    <= 1'b0;
			mem_waddr_r <= 4'h0;
			mem_wdata_r <= 10'h000;
			fan_cnt_r   <= 8'h00;
			tach_prev_r <= 1'b0;
		end else begin
			adc_start   <= 1'b0;
			mem_we_r    <= 1'b0;
			tach_prev_r <= tach_now;
			case (state_r)
				S_IDLE: begin
					if (run) begin
						item_r    <= 4'h0;
						adc_sel   <= `SEL_TEMP;
						adc_start <= 1'b1;
						state_r   <= S_CONV;
					end
				end
				S_CONV: begin
					if (adc_done) begin
						mem_we_r    <= 1'b1;
						mem_waddr_r <= slot_of(item_r);
						mem_wdata_r <= adc_data;
						state_r     <= S_STORE;
					end
				end
				S_FWAIT, S_FCNT: begin
					// full count before an edge stores 255, never wraps
					if (tach_rise && state_r == S_FWAIT) begin
						fan_cnt_r <= 8'h00;
						state_r   <= S_FCNT;
					end else if (tach_rise || (fan_tick && fan_cnt_r == `FAN_MAX)) begin
						mem_we_r    <= 1'b1;
						mem_waddr_r <= slot_of(item_r);
						mem_wdata_r <= {2'h0, fan_cnt_r};
						state_r     <= S_STORE;
					end else if (fan_tick) begin
						fan_cnt_r <= fan_cnt_r + 8'h01;
					end
				end
				S_STORE: begin
					item_r      <= item_nxt;
					fan_cnt_r   <= 8'h00;
					// next item may watch the other pin; mask a false edge
					tach_prev_r <= 1'b1;
					if (!run) begin
						state_r <= S_IDLE;
					end else if (item_nxt < `ITEM_FAN_A) begin
						adc_sel   <= (item_nxt == 4'h0) ? `SEL_TEMP : item_nxt[2:0] - 3'h1;
						adc_start <= 1'b1;
						state_r   <= S_CONV;
					end else if (fan_mode_r[item_nxt[0]]) begin
						// fan in interrupt mode is not measured
						state_r <= S_STORE;
					end else begin
						state_r <= S_FWAIT;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end
endmodule

// ===== verif/hwmon_checker.sv
// port assertions for the monitor sequencer
`timescale 1ns/1ns
module hwmon_checker (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rstn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins and converter
	input wire logic        test_or_reset_input_n,
	input wire logic        adc_start,
	input wire logic [2:0]  adc_sel,
	input wire logic        irq
);
	logic       have_r;
	logic [2:0] last_r;
	wire        cfg_wr = psel && penable && pready && pwrite && paddr == 12'h000;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// any config write may restart the sequence, so order tracking restarts too
	always @(posedge core_clk) begin
		if (!rstn || !test_or_reset_input_n || cfg_wr) begin
			have_r <= 1'b0;
		end else if (adc_start) begin
			have_r <= 1'b1;
			last_r <= adc_sel;
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	a_wait_state: assert property (s_setup ##1 s_wait |=> pready)
		else $error("apb answer late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error reply malformed");
	a_value_ro: assert property (pready && pwrite && paddr >= 12'h080 && paddr <= 12'h0A4
		|-> pslverr)
		else $error("value slot write accepted");
	a_start_pulse: assert property (adc_start |=> !adc_start)
		else $error("start longer than one cycle");
	a_item_order: assert property (adc_start && have_r |-> adc_sel == last_r + 3'h1)
		else $error("conversion order broken");
	a_mask_quiet: assert property (pready && pwrite && !pslverr && paddr == 12'h104
		&& pwdata[2:0] == 3'h0 |=> ##1 !irq)
		else $error("irq high with all masked");
endmodule
bind hw_monitor_sequencer hwmon_checker chk (.core_clk(core_clk), .rstn(rstn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .test_or_reset_input_n(test_or_reset_input_n),
	.adc_start(adc_start), .adc_sel(adc_sel), .irq(irq));

// ===== verif/adc_model.sv
// converter model answering start pulses promptly or slowly
`timescale 1ns/1ns
module adc_model (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rstn,
	// request
	input  wire logic       adc_start,
	input  wire logic [2:0] adc_sel,
	input  wire logic [2:0] adc_range,
	input  wire logic       slow,
	// answer
	output logic            adc_done,
	output logic [9:0]      adc_data
);
	logic [3:0] cnt_r;
	always @(posedge core_clk) begin
		if (!rstn) begin
			cnt_r    <= 4'h0;
			adc_done <= 1'b0;
			adc_data <= 10'h0;
		end else begin
			adc_done <= cnt_r == 4'h1;
			adc_data <= cnt_r == 4'h1 ? {adc_sel, adc_range, 4'h5} : ~adc_data;
			if (adc_start) begin
				cnt_r <= slow ? 4'h9 : 4'h1;
			end else if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule

// ===== verif/hw_monitor_sequencer_bench.sv
// self-checking bench for the monitor sequencer
`timescale 1ns/1ns
`include "hwmon_defs.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module hw_monitor_sequencer_bench;
	logic        core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, er, adc_start, adc_done, irq, slow = 0;
	logic        test_or_reset_input_n = 1, tach_input_a = 0, tach_input_b = 1;
	logic [2:0]  adc_sel, adc_range, rg;
	logic [5:0]  adc_mode, md;
	logic [9:0]  adc_data;
	integer      n_fail = 0, cmp_count = 0, seed = 32'hd0081631, tc = 0, k, s, n_start = 0;
	// tach period of 20 ticks at divisor 1
	localparam   PER = 20 * `TICK_CYC;
	hw_monitor_sequencer dut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .test_or_reset_input_n(test_or_reset_input_n),
		.tach_input_a(tach_input_a), .tach_input_b(tach_input_b), .adc_start(adc_start),
		.adc_sel(adc_sel), .adc_mode(adc_mode), .adc_range(adc_range), .adc_done(adc_done),
		.adc_data(adc_data), .irq(irq));
	adc_model conv (.core_clk(core_clk), .rstn(rstn), .adc_start(adc_start),
		.adc_sel(adc_sel), .adc_range(adc_range), .slow(slow), .adc_done(adc_done),
		.adc_data(adc_data));
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		tc           <= tc == PER - 1 ? 0 : tc + 1;
		tach_input_a <= tc < PER / 2;
		slow         <= $random(seed);
		n_start      <= n_start + adc_start;
	end
	task close_out;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
		integer n;
		@(posedge core_clk);
		psel    <= 1;
		penable <= 0;
		pwrite  <= w;
		paddr   <= {2'h0, ix, 2'h0};
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			close_out();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 0;
		penable <= 0;
	endtask
	function automatic logic [9:0] exp_val(input logic [2:0] sl, input logic [2:0] r);
		return {sl, r, 4'h5};
	endfunction
	initial begin
		repeat (6) @(posedge core_clk);
		rstn <= 1;
		apb(0, `IDX_CFG, 0);      `CHK("cfg", 32'h0, rd)
		apb(0, `IDX_FAN_DIV, 0);  `CHK("fdiv", 32'h50, rd)
		apb(0, `IDX_ADC_CTRL, 0); `CHK("actl", 32'h02, rd)
		apb(0, 8'hFF, 0);         `CHK("unmapped", 1'b1, er)
		rg = $random(seed);
		md = $random(seed);
		apb(1, `IDX_ADC_CTRL, {rg, 3'h2});
		apb(1, `IDX_INPUT_MODE, md);
		repeat (2) @(posedge core_clk);
		`CHK("range", rg, adc_range)
		`CHK("mode", md, adc_mode)
		apb(1, `IDX_FAN_DIV, 32'h40);
		apb(1, `IDX_FAN_MODE, 32'h2);
		apb(1, `IDX_IRQ_MASK, 32'h4);
		apb(1, `IDX_IRQ_STAT, 32'h7);
		apb(1, `IDX_CFG, 32'h1);
		k = 0;
		do begin
			repeat (100) @(posedge core_clk);
			apb(0, `IDX_IRQ_STAT, 0);
			k++;
		end while (rd[0] !== 1'b1 && k < 400);
		`CHK("round", 1'b1, rd[0])
		for (s = 0; s < 8; s++) begin
			apb(0, 8'h20 + s, 0); `CHK("slot", exp_val(s, rg), rd[9:0])
		end
		apb(0, 8'h28, 0);         `CHK("fan", 1'b1, rd >= 19 && rd <= 21)
		apb(1, 8'h20, 32'h3);     `CHK("ro", 1'b1, er)
		tach_input_b <= 0;
		repeat (8) @(posedge core_clk);
		`CHK("irq", 1'b1, irq)
		tach_input_b <= 1;
		repeat (8) @(posedge core_clk);
		apb(1, `IDX_IRQ_STAT, 32'h4);
		repeat (3) @(posedge core_clk);
		`CHK("irqclr", 1'b0, irq)
		tach_input_b <= 0;
		repeat (8) @(posedge core_clk);
		apb(1, `IDX_IRQ_MASK, 32'h0);
		apb(1, `IDX_CFG, 32'h81);
		repeat (3) @(posedge core_clk);
		apb(0, `IDX_CFG, 0);      `CHK("reinit", 32'h0, rd)
		apb(0, `IDX_ADC_CTRL, 0); `CHK("reinit2", 32'h02, rd)
		apb(0, 8'h27, 0);         `CHK("kept", exp_val(7, rg), rd[9:0])
		apb(1, `IDX_FAN_DIV, 32'h0);
		// one cycle is the shortest legal pin pulse
		test_or_reset_input_n <= 0;
		@(posedge core_clk);
		test_or_reset_input_n <= 1;
		repeat (8) @(posedge core_clk);
		apb(0, `IDX_FAN_DIV, 0);  `CHK("pinrst", 32'h50, rd)
		apb(1, `IDX_CFG, 32'h9);
		s = n_start;
		repeat (20) @(posedge core_clk);
		`CHK("held", s, n_start)
		apb(1, `IDX_CFG, 32'h1);
		repeat (3) @(posedge core_clk);
		`CHK("started", 1'b1, n_start > s)
		close_out();
	end
endmodule
